/* load_fault_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module load_fault_monitor
	import fault_pkg::*;
#(
	parameter int RETRY_PERIOD_US = RETRY_PERIOD_US_DEF
) (
	input  wire logic                clk_in,
	input  wire logic                rst_n_in,
	input  wire logic [NUM_CHAN-1:0] chan_cmd_in,
	input  wire logic                retry_variant_in,
	input  wire logic [NUM_CHAN-1:0] drain_sense_in,
	input  wire logic [NUM_CHAN-1:0] ext_ref_input_in,
	input  wire logic                ext_ref_select_in,
	input  wire logic                over_batt_in,
	input  wire logic                under_batt_in,
	input  wire logic                cs_fall_in,
	output var  logic [NUM_CHAN-1:0] gate_drive_out,
	output var  fault_word_t         fault_word_out,
	output var  logic                fault_flag_n_out
);

	// ==========================================
	// derived retry period in ticks
	localparam logic [RETRY_W-1:0] PERIOD_TICKS =
		RETRY_W'(RETRY_PERIOD_US * NS_PER_US / TICK_TIME_NS);
	localparam logic [RETRY_W-1:0] PERIOD_LAST = PERIOD_TICKS - RETRY_W'(1);
	localparam logic [RETRY_W-1:0] PULSE_LAST  = PULSE_TICKS - RETRY_W'(1);

	// ==========================================
	// synchronised comparators and time base
	sense_t              sense_raw;
	sense_t              sense_s;
	logic                tick;
	logic [NUM_CHAN-1:0] drain_high;
	logic                batt_fault;
	logic [NUM_CHAN-1:0] short_flt;
	logic [NUM_CHAN-1:0] open_flt;
	logic [NUM_CHAN-1:0] chan_report;
	logic                any_fault;

	assign sense_raw.over_batt  = over_batt_in;
	assign sense_raw.under_batt = under_batt_in;
	assign sense_raw.ext_cmp    = ext_ref_input_in;
	assign sense_raw.int_cmp    = drain_sense_in;

	bit_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.async_in (sense_raw),
		.sync_out (sense_s)
	);

	tick_gen u_tick (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.tick_out (tick)
	);

	assign drain_high = ext_ref_select_in ? sense_s.ext_cmp : sense_s.int_cmp;

	assign batt_fault = sense_s.over_batt | sense_s.under_batt;

	// ==========================================
	// per-channel supervision
	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++) begin : g_chan
			logic               gate_r;
			logic               gate_nxt;
			logic               cmd_prev_r;
			logic               short_r;
			logic               open_r;
			logic [MASK_W-1:0]  mask_cnt_r;
			logic [DG_W-1:0]    dg_cnt_r;
			logic [RETRY_W-1:0] retry_cnt_r;
			logic               mask_done;
			logic               short_set;
			logic               short_clr;
			logic               pulse_end;
			logic               retry_hi;

			assign mask_done = (mask_cnt_r == MASK_TICKS);
			assign retry_hi  = (retry_cnt_r < PULSE_TICKS);
			assign pulse_end = tick & (retry_cnt_r == PULSE_LAST);

			// short qualified after mask and deglitch
			assign short_set = gate_r & mask_done & drain_high[g]
				& (dg_cnt_r == DEGLITCH_TICKS);

			// off-then-on command clears a latched short
			// retry clears at the end of a pulse if the drain is low then
			assign short_clr = retry_variant_in
				? (~chan_cmd_in[g] | (pulse_end & mask_done & ~drain_high[g]))
				: (chan_cmd_in[g] & ~cmd_prev_r);

			always_comb begin
				gate_nxt = chan_cmd_in[g];
				if (batt_fault) begin
					gate_nxt = 1'b0;
				end else if (short_r & ~short_clr) begin
					gate_nxt = retry_variant_in & chan_cmd_in[g] & retry_hi;
				end
			end

			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					gate_r     <= 1'b0;
					cmd_prev_r <= 1'b0;
				end else begin
					gate_r     <= gate_nxt;
					cmd_prev_r <= chan_cmd_in[g];
				end
			end

			// mask restarts on every gate edge
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					mask_cnt_r <= MASK_RST;
				end else if (gate_nxt != gate_r) begin
					mask_cnt_r <= MASK_RST;
				end else if (tick & ~mask_done) begin
					mask_cnt_r <= mask_cnt_r + MASK_W'(1);
				end
			end

			// drain must stay high for the whole deglitch time
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					dg_cnt_r <= DG_RST;
				end else if (~(gate_r & mask_done & drain_high[g])) begin
					dg_cnt_r <= DG_RST;
				end else if (tick & (dg_cnt_r != DEGLITCH_TICKS)) begin
					dg_cnt_r <= dg_cnt_r + DG_W'(1);
				end
			end

			// set wins over a clear in the same cycle
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					short_r <= 1'b0;
				end else if (short_set) begin
					short_r <= 1'b1;
				end else if (short_clr) begin
					short_r <= 1'b0;
				end
			end

			// retry timer; first phase after a fault is off
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					retry_cnt_r <= RETRY_RST;
				end else if (~short_r) begin
					retry_cnt_r <= PULSE_TICKS;
				end else if (tick) begin
					if (retry_cnt_r >= PERIOD_LAST) begin
						retry_cnt_r <= RETRY_RST;
					end else begin
						retry_cnt_r <= retry_cnt_r + RETRY_W'(1);
					end
				end
			end

			// open load only while off and past the mask
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					open_r <= 1'b0;
				end else begin
					open_r <= ~gate_r & ~gate_nxt & mask_done & ~drain_high[g];
				end
			end

			assign gate_drive_out[g] = gate_r;
			assign short_flt[g]      = short_r;
			assign open_flt[g]       = open_r;
		end
	endgenerate

	// ==========================================
	// reporting
	// one fault bit per channel, hidden during battery fault
	assign chan_report = batt_fault ? '0 : (short_flt | open_flt);

	// battery bits count in the flag
	assign any_fault = (|chan_report) | batt_fault;

	// battery bits are live levels, sampled only at the capture edge
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_word_out <= FAULT_WORD_RST;
		end else if (cs_fall_in) begin
			fault_word_out.over_batt  <= sense_s.over_batt;
			fault_word_out.under_batt <= sense_s.under_batt;
			fault_word_out.unused     <= 1'b0;
			fault_word_out.chan       <= chan_report;
		end
	end

	// flag released at capture only if nothing remains
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_flag_n_out <= 1'b1;
		end else if (any_fault) begin
			fault_flag_n_out <= 1'b0;
		end else if (cs_fall_in) begin
			fault_flag_n_out <= 1'b1;
		end
	end

endmodule : load_fault_monitor

`default_nettype wire

/* fault_pkg.sv */
package fault_pkg;

	// ==========================================
	// geometry
	localparam int NUM_CHAN = 6;
	localparam int SYNC_W   = 2 * NUM_CHAN + 2;

	// ==========================================
	// time base
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_TIME_NS  = 1000;
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int NS_PER_US     = 1000;

	// ==========================================
	// timing, each in microseconds, then in time-base ticks
	localparam int MASK_TIME_US        = 60;
	localparam int SHORT_DEGLITCH_US   = 8;
	localparam int RETRY_PULSE_US      = 68;
	localparam int RETRY_PERIOD_US_DEF = 10000;

	localparam int MASK_W  = 7;
	localparam int DG_W    = 4;
	localparam int RETRY_W = 14;
	localparam int TICK_W  = 6;

	localparam logic [MASK_W-1:0] MASK_TICKS =
		MASK_W'(MASK_TIME_US * NS_PER_US / TICK_TIME_NS);
	localparam logic [DG_W-1:0] DEGLITCH_TICKS =
		DG_W'(SHORT_DEGLITCH_US * NS_PER_US / TICK_TIME_NS);
	localparam logic [RETRY_W-1:0] PULSE_TICKS =
		RETRY_W'(RETRY_PULSE_US * NS_PER_US / TICK_TIME_NS);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// ==========================================
	// reset values
	localparam logic [MASK_W-1:0]  MASK_RST  = 7'h00;
	localparam logic [DG_W-1:0]    DG_RST    = 4'h0;
	localparam logic [RETRY_W-1:0] RETRY_RST = 14'h0000;
	localparam logic [TICK_W-1:0]  TICK_RST  = 6'h00;

	// ==========================================
	// serial fault word layout, bit 8 down to bit 0
	typedef struct packed {
		logic                over_batt;
		logic                under_batt;
		logic                unused;
		logic [NUM_CHAN-1:0] chan;
	} fault_word_t;

	localparam fault_word_t FAULT_WORD_RST = 9'h000;

	// comparator inputs travel together
	typedef struct packed {
		logic                over_batt;
		logic                under_batt;
		logic [NUM_CHAN-1:0] ext_cmp;
		logic [NUM_CHAN-1:0] int_cmp;
	} sense_t;

endpackage : fault_pkg

/* bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module bit_sync
	import fault_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	// ==========================================
	// two-stage synchroniser per bit
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_r;
			logic stable_r;
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					meta_r   <= 1'b0;
					stable_r <= 1'b0;
				end else begin
					meta_r   <= async_in[g];
					stable_r <= meta_r;
				end
			end
			assign sync_out[g] = stable_r;
		end
	endgenerate

endmodule : bit_sync

`default_nettype wire

/* tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none

module tick_gen
	import fault_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	output var  logic tick_out
);

	// ==========================================
	// one-cycle pulse every microsecond
	logic [TICK_W-1:0] div_r;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_r    <= TICK_RST;
			tick_out <= 1'b0;
		end else begin
			tick_out <= (div_r == TICK_LAST);
			if (div_r == TICK_LAST) begin
				div_r <= TICK_RST;
			end else begin
				div_r <= div_r + TICK_W'(1);
			end
		end
	end

endmodule : tick_gen

`default_nettype wire

/* fault_chk_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// load fault checker
module fault_chk
	import fault_pkg::*;
#(
	parameter int RETRY_PERIOD_US = RETRY_PERIOD_US_DEF
) (
	input wire logic                clk_in,
	input wire logic                rst_n_in,
	input wire logic [NUM_CHAN-1:0] chan_cmd_in,
	input wire logic                retry_variant_in,
	input wire logic                over_batt_in,
	input wire logic                under_batt_in,
	input wire logic                cs_fall_in,
	input wire logic [NUM_CHAN-1:0] gate_drive_out,
	input wire fault_word_t         fault_word_out,
	input wire logic                fault_flag_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic batt = over_batt_in | under_batt_in;

	property p_ovr_gate; over_batt_in [*4] |=> gate_drive_out == 6'h00; endproperty
	a_ovr_gate: assert property (p_ovr_gate) else $error("gate on in over battery");
	property p_und_gate; under_batt_in [*4] |=> gate_drive_out == 6'h00; endproperty
	a_und_gate: assert property (p_und_gate) else $error("gate on in under battery");
	property p_ovr_flag; over_batt_in [*5] |=> !fault_flag_n_out; endproperty
	a_ovr_flag: assert property (p_ovr_flag) else $error("no flag on over battery");
	property p_und_flag; under_batt_in [*5] |=> !fault_flag_n_out; endproperty
	a_und_flag: assert property (p_und_flag) else $error("no flag on under battery");
	property p_ovr_word; over_batt_in [*5] ##0 cs_fall_in |=> fault_word_out.over_batt; endproperty
	a_ovr_word: assert property (p_ovr_word) else $error("over bit not captured");
	property p_hide; batt [*5] ##0 cs_fall_in |=> fault_word_out.chan == 6'h00; endproperty
	a_hide: assert property (p_hide) else $error("load fault shown in battery fault");
	property p_bit6; fault_word_out.unused == 1'b0; endproperty
	a_bit6: assert property (p_bit6) else $error("word bit 6 set");
	property p_hold; !cs_fall_in |=> $stable(fault_word_out); endproperty
	a_hold: assert property (p_hold) else $error("word changed without capture");
	property p_rel; $rose(fault_flag_n_out) |-> $past(cs_fall_in); endproperty
	a_rel: assert property (p_rel) else $error("flag released without capture");
	property p_on; $rose(gate_drive_out[0]) && !retry_variant_in |-> $past(chan_cmd_in[0]);
	endproperty
	a_on: assert property (p_on) else $error("gate rose without command");
endmodule : fault_chk

bind load_fault_monitor fault_chk #(.RETRY_PERIOD_US(RETRY_PERIOD_US)) u_chk (
	.clk_in, .rst_n_in, .chan_cmd_in, .retry_variant_in, .over_batt_in, .under_batt_in,
	.cs_fall_in, .gate_drive_out, .fault_word_out, .fault_flag_n_out);
`default_nettype wire

/* load_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// external fet and load
module load_model
	import fault_pkg::*;
(
	input  wire logic [NUM_CHAN-1:0] gate_in,
	input  wire logic [NUM_CHAN-1:0] short_in,
	input  wire logic [NUM_CHAN-1:0] open_in,
	output var  logic [NUM_CHAN-1:0] drain_out
);
	// shorted drain stays high when on; open drain sinks low when off
	always_comb drain_out = (gate_in & short_in) | (~gate_in & ~open_in);
endmodule : load_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module tb_top;
	import fault_pkg::*;
	localparam int RP = 200;
	localparam int US = 50;
	logic                clk_in = 1'b0, rst_n_in = 1'b0, retry = 1'b0, sel = 1'b0;
	logic                ov = 1'b0, un = 1'b0, cs = 1'b0, flag_n;
	logic [NUM_CHAN-1:0] cmd = 6'h00, sh = 6'h00, op = 6'h00, ext = 6'h3f, m, gate, drain;
	fault_word_t         word;
	int                  n_fail = 0, total_checks = 0, cnt;

	load_fault_monitor #(.RETRY_PERIOD_US(RP)) DUT (.clk_in, .rst_n_in, .chan_cmd_in(cmd),
		.retry_variant_in(retry), .drain_sense_in(drain), .ext_ref_input_in(ext),
		.ext_ref_select_in(sel), .over_batt_in(ov), .under_batt_in(un), .cs_fall_in(cs),
		.gate_drive_out(gate), .fault_word_out(word), .fault_flag_n_out(flag_n));
	load_model u_load (.gate_in(gate), .short_in(sh), .open_in(op), .drain_out(drain));

	initial forever #10 clk_in = ~clk_in;

	// battery fault hides channel bits
	function automatic logic [8:0] exp_w(input logic o, u, input logic [5:0] c);
		return (o | u) ? {o, u, 7'h00} : {3'b000, c};
	endfunction : exp_w

	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : step

	task automatic chk(input string nm, input logic [8:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic rd(input logic [8:0] e);
		cs = 1'b1;
		step(1);
		cs = 1'b0;
		step(1);
		chk("word", e, word);
		chk("flag_n", {8'h00, e == 9'h000}, {8'h00, flag_n});
	endtask : rd

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	initial begin
		#(80000 * 20);
		n_fail++;
		summarize();
	end

	initial begin
		void'($urandom(32'h782f1070));
		repeat (6) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		step(10);
		rd(9'h000);
		op = 6'($urandom());
		step(70 * US);
		rd(exp_w(1'b0, 1'b0, op));
		sel = 1'b1;
		ext = 6'($urandom());
		step(10);
		rd(exp_w(1'b0, 1'b0, ~ext));
		sel = 1'b0;
		op = 6'h00;
		$display("open load test done");
		sh = 6'($urandom()) | 6'h01;
		m = sh;
		cmd = 6'h3f;
		step(50 * US);
		chk("gate_mask", {3'b000, cmd}, {3'b000, gate});
		step(30 * US);
		chk("gate_cut", {3'b000, ~m}, {3'b000, gate});
		rd(exp_w(1'b0, 1'b0, m));
		sh = 6'h00;
		step(100);
		chk("gate_hold", {3'b000, ~m}, {3'b000, gate});
		cmd = 6'h00;
		step(2);
		cmd = 6'h3f;
		step(80 * US);
		rd(9'h000);
		$display("shut-off test done");
		retry = 1'b1;
		sh = 6'h01;
		step(80 * US);
		cnt = 0;
		repeat (RP * US) begin
			step(1);
			cnt += int'(gate[0]);
		end
		chk("retry_on", 9'h001, {8'h00, cnt >= 67 * US && cnt <= 69 * US});
		rd(exp_w(1'b0, 1'b0, 6'h01));
		sh = 6'h00;
		step((RP + 80) * US);
		rd(9'h000);
		retry = 1'b0;
		$display("retry test done");
		cmd = 6'h0f;
		op = 6'h30;
		step(80 * US);
		for (int i = 0; i < 2; i++) begin
			{ov, un} = 2'b10 >> i;
			step(10);
			chk("gate_lock", 9'h000, {3'b000, gate});
			rd(exp_w(ov, un, 6'h00));
			{ov, un} = 2'b00;
			step(10);
			chk("gate_back", {3'b000, cmd}, {3'b000, gate});
			rd(exp_w(1'b0, 1'b0, op));
		end
		$display("battery test done");
		summarize();
	end
endmodule : tb_top
`default_nettype wire
